// ==== logic/qec_defines.svh ====
`ifndef QEC_DEFINES_SVH
`define QEC_DEFINES_SVH

// System clock and fastest encoder pulse rate
`define QEC_CLK_HZ 40000000
`define QEC_MAX_PULSE_HZ 10000
// Cycles between two phase edges at the fastest rate, rounded down
`define QEC_EDGE_CYCLES (`QEC_CLK_HZ / (4 * `QEC_MAX_PULSE_HZ))

// Register byte offsets
`define QEC_ADDR_W 8
`define QEC_CTRL_OFS 8'h00
`define QEC_STATUS_OFS 8'h04
`define QEC_MASK_OFS 8'h08
`define QEC_COUNT0_OFS 8'h0C
`define QEC_COUNT1_OFS 8'h10
`define QEC_CMP0_OFS 8'h14
`define QEC_CMP1_OFS 8'h18

// Control register fields
`define QEC_CTRL_MODE_LSB 0
`define QEC_CTRL_OWN_LSB 2
`define QEC_CTRL_ARMED_LSB 4

// Reset values
`define QEC_OWN_RST 2'h0
`define QEC_MASK_RST 2'h0
`define QEC_COUNT_RST 32'sh00000000
`define QEC_CMP_RST 32'sh00000000

// Bus responses
`define QEC_RESP_OKAY 2'h0
`define QEC_RESP_SLVERR 2'h2

`endif

// ==== logic/qec_pkg.sv ====
package qec_pkg;
  typedef logic signed [31:0] qec_count_type;
  typedef enum logic [1:0] {
    QEC_MODE_SIMPLE,
    QEC_MODE_ENH_CH0,
    QEC_MODE_ENH_CH1,
    QEC_MODE_ENH_BOTH
  } qec_mode_type;
endpackage

// ==== logic/qec_sync.sv ====
`timescale 1ns/1ps
module qec_sync
  import qec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw pins and their synchronised levels
  input wire logic [3:0] raw_in,
  output logic [3:0] sync_q
);
  logic [3:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  property p_two_stage;
    @(posedge aclk) disable iff (!aresetn)
    ##2 sync_q == $past(raw_in, 2);
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("pin not delayed by two stages");
endmodule

// ==== logic/qec_decoder.sv ====
`timescale 1ns/1ps
module qec_decoder
  import qec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Synchronised phases
  input wire logic phase_a,
  input wire logic phase_b,
  // Decode selection and pin ownership
  input wire logic enhanced,
  input wire logic enable,
  // One-cycle count steps
  output logic step_up_q,
  output logic step_dn_q
);
  logic a_prev_q;
  logic b_prev_q;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= phase_a;
      b_prev_q <= phase_b;
    end
  end

  // Edges seen on every clock, far faster than the pulse rate
  assign a_rise = phase_a & ~a_prev_q;
  assign a_fall = ~phase_a & a_prev_q;
  assign b_rise = phase_b & ~b_prev_q;
  assign b_fall = ~phase_b & b_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
    end else if (!enable) begin
      step_up_q <= 1'b0;
      step_dn_q <= 1'b0;
    end else if (enhanced) begin
      // A rising then falling at the same B level cancels out
      step_up_q <= a_rise & ~phase_b;
      step_dn_q <= a_fall & ~phase_b;
    end else begin
      // B idle lets A alone count up
      step_up_q <= a_rise & ~phase_b;
      step_dn_q <= b_rise & ~phase_a;
    end
  end

  sequence s_enh_a_fall;
    enable && enhanced && a_fall && !phase_b;
  endsequence
  sequence s_b_moves;
    enable && enhanced && (b_rise || b_fall) && !a_rise && !a_fall;
  endsequence

  property p_simple_up;
    @(posedge aclk) disable iff (!aresetn)
    (enable && !enhanced && a_rise && !phase_b) |=> step_up_q && !step_dn_q;
  endproperty
  a_simple_up: assert property (p_simple_up) else $error("A pulse with B off did not count up");

  property p_simple_dn;
    @(posedge aclk) disable iff (!aresetn)
    (enable && !enhanced && b_rise && !phase_a) |=> step_dn_q && !step_up_q;
  endproperty
  a_simple_dn: assert property (p_simple_dn) else $error("B pulse with A off did not count down");

  property p_enh_lock;
    @(posedge aclk) disable iff (!aresetn)
    s_enh_a_fall |=> step_dn_q;
  endproperty
  a_enh_lock: assert property (p_enh_lock) else $error("enhanced A fall did not undo count");

  property p_enh_b_quiet;
    @(posedge aclk) disable iff (!aresetn)
    s_b_moves |=> !step_up_q && !step_dn_q;
  endproperty
  a_enh_b_quiet: assert property (p_enh_b_quiet) else $error("enhanced B edge counted");
endmodule

// ==== logic/qec_counter.sv ====
`timescale 1ns/1ps
`include "qec_defines.svh"
// Functional notes
// - Two independent counter channels, each with its own phase A and phase B pin pair.
// - Each channel counts pulse trains up to 10 kHz without losing counts.
// - A leading B makes the channel count up by one per pulse.
// - A lagging B makes the channel count down by one per pulse.
// - In simple decoding A pulses with B off count up.
// - In simple decoding B pulses with A off count down.
// - The second channel uses its own pins and behaves exactly like the first.
// - Reaching the armed compare value raises a match event and starts the user action.
// - The two-bit mode picks simple or enhanced decoding per channel, 0 to 3.
// - Enhanced decoding checks both phases so edge jitter cannot count repeatedly.
// - Simple decoding is the default and counts a single-phase train on A alone.
// - Each count is a signed 32-bit value readable by firmware and compared.
// - A counter pin serves one special function; the latest configured one owns it.
module qec_counter
  import qec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Encoder phases: bit 0 ch0 A, 1 ch0 B, 2 ch1 A, 3 ch1 B
  input wire logic [3:0] phase_in,
  // Another special input function takes a channel's pins
  input wire logic [1:0] alt_claim,
  // AXI4-Lite write address
  input wire logic [`QEC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`QEC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Match action start and interrupt
  output logic [1:0] user_action_start,
  output logic irq
);
  localparam logic [`QEC_ADDR_W-1:0] COUNT_OFS [2] = '{`QEC_COUNT0_OFS, `QEC_COUNT1_OFS};
  localparam logic [`QEC_ADDR_W-1:0] CMP_OFS [2] = '{`QEC_CMP0_OFS, `QEC_CMP1_OFS};

  function automatic qec_count_type next_count(input qec_count_type c, input logic up,
                                               input logic dn);
    // Plain 32-bit arithmetic wraps in two's complement
    if (up) begin
      return c + 32'sh00000001;
    end
    if (dn) begin
      return c - 32'sh00000001;
    end
    return c;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (st[k]) begin
        r[8*k +: 8] = wd[8*k +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_mapped(input logic [`QEC_ADDR_W-1:0] a);
    return a == `QEC_CTRL_OFS || a == `QEC_STATUS_OFS || a == `QEC_MASK_OFS ||
           a == `QEC_COUNT0_OFS || a == `QEC_COUNT1_OFS ||
           a == `QEC_CMP0_OFS || a == `QEC_CMP1_OFS;
  endfunction

  logic [3:0] phase_sync;
  logic [1:0] up;
  logic [1:0] dn;
  qec_mode_type mode_q;
  logic [1:0] mode_bits;
  logic [1:0] own_q;
  logic [1:0] armed_q;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] match_hit;
  logic [1:0] action_q;
  logic irq_q;
  qec_count_type count_q [2];
  qec_count_type cmp_q [2];
  qec_count_type next_cnt [2];
  logic [1:0] wr_count;
  logic [1:0] wr_cmp;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_en;
  logic rd_take;
  logic rd_status;
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_w;
  logic [31:0] rd_word;

  logic awready_q;
  logic aw_hold_q;
  logic [`QEC_ADDR_W-1:0] awaddr_q;
  logic wready_q;
  logic w_hold_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign mode_bits = mode_q;

  qec_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(phase_in),
    .sync_q(phase_sync)
  );

  // Identical channels, each on its own pin pair
  for (genvar g = 0; g < 2; g++) begin : g_chan
    qec_decoder u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .phase_a(phase_sync[2*g]),
      .phase_b(phase_sync[2*g+1]),
      .enhanced(mode_bits[g]),
      .enable(own_q[g]),
      .step_up_q(up[g]),
      .step_dn_q(dn[g])
    );
  end

  // Write side of the bus
  assign wr_en = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_ctrl = wr_en && awaddr_q == `QEC_CTRL_OFS;
  assign wr_mask = wr_en && awaddr_q == `QEC_MASK_OFS;
  assign rd_take = s_axi_arvalid & arready_q;
  assign rd_status = rd_take && s_axi_araddr == `QEC_STATUS_OFS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_hold_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `QEC_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(awaddr_q) ? `QEC_RESP_OKAY : `QEC_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read side of the bus
  always_comb begin
    ctrl_word = 32'h00000000;
    ctrl_word[`QEC_CTRL_MODE_LSB +: 2] = mode_bits;
    ctrl_word[`QEC_CTRL_OWN_LSB +: 2] = own_q;
    ctrl_word[`QEC_CTRL_ARMED_LSB +: 2] = armed_q;
    ctrl_w = merge_bytes(ctrl_word, wdata_q, wstrb_q);
    unique case (s_axi_araddr)
      `QEC_CTRL_OFS: rd_word = ctrl_word;
      `QEC_STATUS_OFS: rd_word = {30'h00000000, status_q};
      `QEC_MASK_OFS: rd_word = {30'h00000000, mask_q};
      `QEC_COUNT0_OFS: rd_word = count_q[0];
      `QEC_COUNT1_OFS: rd_word = count_q[1];
      `QEC_CMP0_OFS: rd_word = cmp_q[0];
      `QEC_CMP1_OFS: rd_word = cmp_q[1];
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `QEC_RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= addr_mapped(s_axi_araddr) ? `QEC_RESP_OKAY : `QEC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Next count and match detection per channel
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_count[i] = wr_en && awaddr_q == COUNT_OFS[i];
      wr_cmp[i] = wr_en && awaddr_q == CMP_OFS[i];
      next_cnt[i] = next_count(count_q[i], up[i], dn[i]);
      match_hit[i] = armed_q[i] && (up[i] || dn[i]) && !wr_count[i] &&
                     next_cnt[i] == cmp_q[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        count_q[i] <= `QEC_COUNT_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_count[i]) begin
          count_q[i] <= qec_count_type'(merge_bytes(count_q[i], wdata_q, wstrb_q));
        end else begin
          count_q[i] <= next_cnt[i];
        end
      end
    end
  end

  // A new compare value re-arms the channel; a match disarms it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        cmp_q[i] <= `QEC_CMP_RST;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_cmp[i]) begin
          cmp_q[i] <= qec_count_type'(merge_bytes(cmp_q[i], wdata_q, wstrb_q));
          armed_q[i] <= 1'b1;
        end else if (match_hit[i]) begin
          armed_q[i] <= 1'b0;
        end
      end
    end
  end

  // Decode mode and pin ownership
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= QEC_MODE_SIMPLE;
      own_q <= `QEC_OWN_RST;
    end else if (wr_ctrl) begin
      mode_q <= qec_mode_type'(ctrl_w[`QEC_CTRL_MODE_LSB +: 2]);
      own_q <= ctrl_w[`QEC_CTRL_OWN_LSB +: 2];
    end else begin
      own_q <= own_q & ~alt_claim;
    end
  end

  // Sticky status: a match in the clearing read's cycle survives
  assign status_d = (status_q & ~{2{rd_status}}) | match_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 2'h0;
      mask_q <= `QEC_MASK_RST;
      action_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_mask) begin
        mask_q <= wstrb_q[0] ? wdata_q[1:0] : mask_q;
      end
      action_q <= match_hit;
      irq_q <= |(status_d & mask_q);
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign user_action_start = action_q;
  assign irq = irq_q;

  sequence s_count0_read;
    rd_take && s_axi_araddr == `QEC_COUNT0_OFS;
  endsequence

  property p_up_count;
    @(posedge aclk) disable iff (!aresetn)
    (up[0] && !wr_count[0]) |=> count_q[0] == $past(count_q[0]) + 32'sh00000001;
  endproperty
  a_up_count: assert property (p_up_count) else $error("channel 0 did not count up");

  property p_dn_count;
    @(posedge aclk) disable iff (!aresetn)
    (dn[0] && !up[0] && !wr_count[0]) |=> count_q[0] == $past(count_q[0]) - 32'sh00000001;
  endproperty
  a_dn_count: assert property (p_dn_count) else $error("channel 0 did not count down");

  property p_ch1_dn;
    @(posedge aclk) disable iff (!aresetn)
    (dn[1] && !up[1] && !wr_count[1]) |=> count_q[1] == $past(count_q[1]) - 32'sh00000001;
  endproperty
  a_ch1_dn: assert property (p_ch1_dn) else $error("channel 1 did not count down");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    (up[0] && !wr_count[0] && count_q[0] == 32'sh7FFFFFFF) |=> count_q[0] == 32'sh80000000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");

  property p_match;
    @(posedge aclk) disable iff (!aresetn)
    (match_hit[0] && !wr_cmp[0]) |=> status_q[0] && user_action_start[0] && !armed_q[0];
  endproperty
  a_match: assert property (p_match) else $error("match not flagged");

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    (rd_status && match_hit[1]) |=> status_q[1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("match lost to status read");

  property p_claim;
    @(posedge aclk) disable iff (!aresetn)
    (alt_claim[1] && !wr_ctrl) |=> !own_q[1] ##1 !up[1] && !dn[1];
  endproperty
  a_claim: assert property (p_claim) else $error("claimed pin still counting");

  property p_read_count;
    @(posedge aclk) disable iff (!aresetn)
    s_count0_read |=> s_axi_rvalid && s_axi_rdata == $past(count_q[0]);
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

  property p_reset;
    @(posedge aclk)
    !aresetn |=> count_q[0] == 32'sh00000000 && count_q[1] == 32'sh00000000 &&
                 armed_q == 2'h0 && mode_q == QEC_MODE_SIMPLE;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    ##1 irq == |(status_q & $past(mask_q));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

// ==== test/qec_encoder_model.sv ====
`timescale 1ns/1ps
module qec_encoder_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pulse request: channel, kind (0 fwd, 1 rev, 2 A only, 3 B only), cycles per level
  input wire logic cmd_valid,
  input wire logic cmd_ch,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_hold,
  // Progress and encoder pins
  output logic busy,
  output logic [3:0] phase_out
);
  // Levels {B,A} of the four quarters of one pulse, kind 0 in the low byte
  localparam logic [31:0] SEQ = {8'h02, 8'h01, 8'h1E, 8'h2D};
  logic ch_q;
  logic [1:0] kind_q;
  logic [1:0] step_q;
  logic [15:0] hold_q;
  logic [15:0] cnt_q;
  logic [1:0] lvl;

  assign lvl = SEQ[{kind_q, step_q, 1'b0} +: 2];
  // Idle pins rest low so both phases read off between pulses
  assign phase_out = (busy !== 1'b1) ? 4'h0 : (ch_q ? {lvl, 2'h0} : {2'h0, lvl});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      step_q <= 2'h0;
      cnt_q <= 16'h1;
    end else if (!busy) begin
      if (cmd_valid) begin
        busy <= 1'b1;
        ch_q <= cmd_ch;
        kind_q <= cmd_kind;
        hold_q <= cmd_hold;
        step_q <= 2'h0;
        cnt_q <= 16'h1;
      end
    end else if (cnt_q < hold_q) begin
      cnt_q <= cnt_q + 16'h1;
    end else begin
      cnt_q <= 16'h1;
      step_q <= step_q + 2'h1;
      if (step_q == 2'h3) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// ==== test/quadrature_encoder_counter_tb_top.sv ====
`timescale 1ns/1ps
`include "qec_defines.svh"
module quadrature_encoder_counter_tb_top
  import qec_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, irq;
  logic arvalid, arready, rvalid, rready, cmd_valid, cmd_ch, busy;
  logic [`QEC_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, phase_in;
  logic [1:0] bresp, rresp, alt_claim, uas, cmd_kind, mode_now, own_now;
  logic [15:0] cmd_hold;
  int num_errors, n_compared, pulses0, pulses1;
  qec_count_type exp_cnt [2];

  qec_counter qec_counter_i (.aclk(aclk), .aresetn(aresetn), .phase_in(phase_in),
    .alt_claim(alt_claim), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .user_action_start(uas), .irq(irq));

  qec_encoder_model qec_encoder_model_i (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(cmd_valid), .cmd_ch(cmd_ch), .cmd_kind(cmd_kind), .cmd_hold(cmd_hold),
    .busy(busy), .phase_out(phase_in));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count match action pulses per channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      pulses0 <= 0;
      pulses1 <= 0;
    end else begin
      pulses0 <= pulses0 + int'(uas[0] === 1'b1);
      pulses1 <= pulses1 + int'(uas[1] === 1'b1);
    end
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    give_up(n, 100);
    check(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    give_up(n, 100);
    check(32'(rresp), 32'(er));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, `QEC_RESP_OKAY);
    check(d, e);
  endtask

  task automatic set_ctrl(input logic [1:0] m, input logic [1:0] o);
    wr(`QEC_CTRL_OFS, 32'({o, m}), `QEC_RESP_OKAY);
    mode_now = m;
    own_now = o;
  endtask

  function automatic qec_count_type delta(input logic [1:0] kind, input logic enh);
    case (kind)
      2'h0: return 1;
      2'h1: return -1;
      2'h2: return enh ? 0 : 1;
      default: return enh ? 0 : -1;
    endcase
  endfunction

  task automatic play(input logic ch, input logic [1:0] kind, input logic [15:0] hold);
    int n;
    cmd_ch <= ch;
    cmd_kind <= kind;
    cmd_hold <= hold;
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 70000; n++) begin
      @(posedge aclk);
      if (busy === 1'b0) break;
    end
    give_up(n, 70000);
    repeat (6) @(posedge aclk);
    if (own_now[ch]) exp_cnt[ch] += delta(kind, mode_now[ch]);
  endtask

  task automatic chk_counts();
    rd_chk(`QEC_COUNT0_OFS, exp_cnt[0]);
    rd_chk(`QEC_COUNT1_OFS, exp_cnt[1]);
  endtask

  initial begin
    int i;
    int m;
    int k;
    logic [31:0] d;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, cmd_valid, cmd_ch} = 8'h00;
    {awaddr, araddr, wdata, alt_claim, cmd_kind, cmd_hold} = '0;
    wstrb = 4'hF;
    num_errors = 0;
    n_compared = 0;
    exp_cnt[0] = 0;
    exp_cnt[1] = 0;
    mode_now = 2'h0;
    own_now = 2'h0;
    void'($urandom(97));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++) rd_chk(8'(4 * i), 32'h0);
    check(32'({irq, uas}), 32'h0);
    play(0, 2'h0, 16'h3);
    chk_counts();
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      set_ctrl(2'(m), 2'h3);
      for (k = 0; k < 4; k++) begin
        play(0, 2'(k), 16'h3);
        play(1, 2'(k), 16'h3);
        chk_counts();
      end
    end
    $display("test modes done");
    for (i = 0; i < 40; i++) begin
      if (i % 10 == 0) set_ctrl(2'($urandom_range(3)), 2'h3);
      play(1'($urandom_range(1)), 2'($urandom_range(3)), 16'($urandom_range(20, 3)));
    end
    chk_counts();
    play(0, 2'h0, 16'(`QEC_EDGE_CYCLES));
    chk_counts();
    $display("test random done");
    wr(`QEC_COUNT0_OFS, 32'h7FFFFFFF, `QEC_RESP_OKAY);
    wr(`QEC_COUNT1_OFS, 32'h80000000, `QEC_RESP_OKAY);
    exp_cnt[0] = 32'sh7FFFFFFF;
    exp_cnt[1] = 32'sh80000000;
    play(0, 2'h0, 16'h3);
    play(1, 2'h1, 16'h3);
    chk_counts();
    $display("test wrap done");
    wr(`QEC_MASK_OFS, 32'h1, `QEC_RESP_OKAY);
    wr(`QEC_COUNT0_OFS, 32'h5, `QEC_RESP_OKAY);
    wr(`QEC_COUNT1_OFS, 32'hA, `QEC_RESP_OKAY);
    wr(`QEC_CMP0_OFS, 32'h6, `QEC_RESP_OKAY);
    wr(`QEC_CMP1_OFS, 32'h9, `QEC_RESP_OKAY);
    exp_cnt[0] = 5;
    exp_cnt[1] = 10;
    rd_chk(`QEC_CTRL_OFS, 32'({2'h3, own_now, mode_now}));
    play(1, 2'h1, 16'h3);
    check(32'({irq, 7'h0, 8'(pulses1), 8'(pulses0)}), 32'h0100);
    play(0, 2'h0, 16'h3);
    check(32'({irq, 7'h0, 8'(pulses1), 8'(pulses0)}), 32'h00800101);
    rd_chk(`QEC_STATUS_OFS, 32'h3);
    rd_chk(`QEC_STATUS_OFS, 32'h0);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    rd_chk(`QEC_CTRL_OFS, 32'({own_now, mode_now}));
    play(0, 2'h0, 16'h3);
    play(0, 2'h1, 16'h3);
    check(32'(pulses0), 32'h1);
    chk_counts();
    $display("test match done");
    alt_claim <= 2'h2;
    @(posedge aclk);
    alt_claim <= 2'h0;
    own_now[1] = 1'b0;
    rd_chk(`QEC_CTRL_OFS, 32'({own_now, mode_now}));
    play(1, 2'h0, 16'h3);
    chk_counts();
    $display("test pin claim done");
    wr(8'h40, 32'hFFFFFFFF, `QEC_RESP_SLVERR);
    rd(8'h40, d, `QEC_RESP_SLVERR);
    check(d, 32'h0);
    wr(8'h02, 32'hFFFFFFFF, `QEC_RESP_SLVERR);
    chk_counts();
    $display("test unmapped done");
    end_of_test();
  end
endmodule
